// ---- hw/spms_port.v ----
// Master/slave serial peripheral port with register port, baud generator and shifter
`timescale 1ns/10ps
`include "spms_map.vh"
module spms_port #(
    parameter WIDTH = 8,
    parameter CNT_W = 16
) (
    input  wire             sys_clk_in,
    input  wire             rst_n_in,
    input  wire [2:0]       addr_in,
    input  wire [7:0]       wdata_in,
    input  wire             wr_in,
    input  wire             rd_in,
    output reg  [7:0]       rdata_out,
    input  wire             sck_in,
    output reg              sck_out,
    output wire             sck_oe_out,
    input  wire             mosi_in,
    output wire             mosi_out,
    output wire             mosi_oe_out,
    input  wire             miso_in,
    output wire             miso_out,
    output wire             miso_oe_out,
    input  wire             ss_n_in,
    output wire             irq_out
);
    // ==================================================
    // State encoding
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_XFER = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // ==================================================
    // Registers
    reg  [7:0]       ctrl;
    reg  [7:0]       prescale;
    reg  [WIDTH-1:0] rx_buf;
    reg              done_flag;
    reg              write_collision_flag_flag;
    reg              master_fault_flag_flag;
    reg              done_armed;
    reg              write_collision_flag_armed;
    reg              master_fault_flag_armed;
    reg  [2:0]       state;
    reg  [4:0]       edge_cnt;
    reg              sck_prev;
    reg              slave_started;

    wire             is_master;
    wire             clock_polarity;
    wire             clock_phase;
    wire             port_on;
    wire             hit_data;
    wire             hit_status;
    wire             hit_ctrl;
    wire             hit_pre;
    wire             busy;
    wire             data_write;
    wire             write_ok;
    wire             start_master;
    wire             baud_tick;
    wire             slave_edge;
    wire             ser_edge;
    wire             lead_edge;
    wire             sample;
    wire             shift;
    wire             last_edge;
    wire             serial_in;
    wire             shift_msb;
    wire [WIDTH-1:0] shift_data;
    wire             fault;
    wire             ctrl_write;
    wire             done_block;
    wire             ss_freeze;
    wire             xfer_act;
    wire             first_edge;
    wire [7:0]       status_word;

    function hit;
        input [2:0] a;
        input [2:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign is_master  = ctrl[`SPMS_CTRL_MASTER];
    assign clock_polarity       = ctrl[`SPMS_CTRL_CLOCK_POLARITY];
    assign clock_phase       = ctrl[`SPMS_CTRL_CLOCK_PHASE];
    assign port_on    = ctrl[`SPMS_CTRL_POE];
    assign hit_data   = hit(addr_in, `SPMS_OFF_DATA);
    assign hit_status = hit(addr_in, `SPMS_OFF_STATUS);
    assign hit_ctrl   = hit(addr_in, `SPMS_OFF_CTRL);
    assign hit_pre    = hit(addr_in, `SPMS_OFF_PRESCALE);
    assign busy       = (state == ST_XFER);
    assign data_write = wr_in && hit_data;
    assign ctrl_write = wr_in && hit_ctrl;

    // ==================================================
    // Data register write qualification
    assign done_block = done_flag && !done_armed;
    // Phase clear: any SS low freezes; phase set: only once the first edge came
    assign ss_freeze  = !is_master && !ss_n_in && (!clock_phase || slave_started);
    assign write_ok   = data_write && !busy && !done_block && !ss_freeze;
    assign start_master = write_ok && is_master && port_on && ss_n_in;

    // ==================================================
    // Rate generator, master only
    spms_baud_gen #(
        .CNT_W (CNT_W)
    ) u_baud (
        .sys_clk_in            (sys_clk_in),
        .rst_n_in              (rst_n_in),
        .run_in                (busy && is_master),
        .half_divide_select_in (prescale[`SPMS_PRE_HALF]),
        .prescale_in           (prescale[`SPMS_PRE_VAL_HI:0]),
        .rate_select_in        (ctrl[`SPMS_CTRL_RATE_HI:`SPMS_CTRL_RATE_LO]),
        .tick_out              (baud_tick)
    );

    // ==================================================
    // Serial edge detection; pins taken as synchronous
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            sck_prev <= 1'b0;
        else
            sck_prev <= sck_in;
    end

    // Slave edges only count with SS low and port enabled; prescaler unused
    assign slave_edge = !is_master && port_on && !ss_n_in && (sck_in != sck_prev);
    assign ser_edge   = is_master ? baud_tick : slave_edge;
    // Odd edges (1st,3rd,...) are leading edges of a pulse
    assign lead_edge  = !edge_cnt[0];
    // Slave edge one arrives while idle, so it is processed there as well
    assign xfer_act   = busy || (state == ST_IDLE && slave_edge);
    // Phase set: the MSB already stands from the load, so edge one must not shift
    assign first_edge = (edge_cnt == 5'h00);
    assign sample     = xfer_act && ser_edge && (lead_edge ^ clock_phase);
    assign shift      = xfer_act && ser_edge && !(lead_edge ^ clock_phase) && !(clock_phase && first_edge);
    assign last_edge  = ser_edge && (edge_cnt == `SPMS_EDGES_PER_BYTE - 5'h01);
    assign serial_in  = is_master ? miso_in : mosi_in;

    spms_shifter #(
        .WIDTH (WIDTH)
    ) u_shift (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .load_in      (write_ok),
        .load_data_in (wdata_in),
        .sample_in    (sample),
        .serial_in    (serial_in),
        .shift_in     (shift),
        .msb_out      (shift_msb),
        .data_out     (shift_data)
    );

    // ==================================================
    // Transfer sequencer
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state         <= ST_IDLE;
            edge_cnt      <= 5'h00;
            slave_started <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    edge_cnt <= 5'h00;
                    if (start_master) begin
                        state <= ST_XFER;
                    end else if (slave_edge) begin
                        // First slave edge counts as edge one of the byte
                        state         <= ST_XFER;
                        edge_cnt      <= 5'h01;
                        slave_started <= 1'b1;
                    end
                end
                ST_XFER: begin
                    if (fault) begin
                        state <= ST_IDLE;
                    end else if (last_edge) begin
                        state <= ST_DONE;
                    end else if (ser_edge) begin
                        edge_cnt <= edge_cnt + 5'h01;
                    end
                end
                ST_DONE: begin
                    state         <= ST_IDLE;
                    slave_started <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (ss_n_in)
                slave_started <= 1'b0;
        end
    end

    // ==================================================
    // Serial clock out: idle at polarity, toggles per tick in master transfer
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            sck_out <= 1'b0;
        else if (!busy || !is_master)
            sck_out <= clock_polarity;
        else if (baud_tick)
            sck_out <= ~sck_out;
    end

    // ==================================================
    // Pin drivers
    assign sck_oe_out  = is_master && port_on;
    assign mosi_out    = shift_msb;
    assign mosi_oe_out = is_master && port_on;
    assign miso_out    = shift_msb;
    assign miso_oe_out = !is_master && port_on && !ss_n_in;

    // ==================================================
    // Flags; hardware set wins over software clear
    assign fault = is_master && port_on && !ss_n_in;

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            done_flag  <= 1'b0;
            done_armed <= 1'b0;
            write_collision_flag_flag  <= 1'b0;
            write_collision_flag_armed <= 1'b0;
            master_fault_flag_flag  <= 1'b0;
            master_fault_flag_armed <= 1'b0;
            rx_buf     <= `SPMS_RST_BYTE;
        end else begin
            if ((rd_in || wr_in) && hit_status && done_flag)
                done_armed <= 1'b1;
            else if (rd_in && hit_data && done_armed)
                done_armed <= 1'b0;
            if (rd_in && hit_data && done_armed)
                done_flag <= 1'b0;
            if (state == ST_XFER && last_edge) begin
                done_flag  <= 1'b1;
                done_armed <= 1'b0;
                rx_buf     <= shift_data;
            end
            if (rd_in && hit_status && write_collision_flag_flag)
                write_collision_flag_armed <= 1'b1;
            else if (rd_in && hit_data && write_collision_flag_armed)
                write_collision_flag_armed <= 1'b0;
            if (rd_in && hit_data && write_collision_flag_armed)
                write_collision_flag_flag <= 1'b0;
            if (data_write && busy) begin
                write_collision_flag_flag  <= 1'b1;
                write_collision_flag_armed <= 1'b0;
            end
            if (rd_in && hit_status && master_fault_flag_flag)
                master_fault_flag_armed <= 1'b1;
            else if (ctrl_write)
                master_fault_flag_armed <= 1'b0;
            if (ctrl_write && master_fault_flag_armed)
                master_fault_flag_flag <= 1'b0;
            if (fault) begin
                master_fault_flag_flag  <= 1'b1;
                master_fault_flag_armed <= 1'b0;
            end
        end
    end

    // ==================================================
    // Control and prescaler registers
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl     <= `SPMS_RST_CTRL;
            prescale <= `SPMS_RST_PRESCALE;
        end else begin
            if (ctrl_write) begin
                ctrl <= wdata_in;
                // Fault blocks re-enable except inside its clearing sequence
                if (master_fault_flag_flag && !master_fault_flag_armed) begin
                    ctrl[`SPMS_CTRL_POE]    <= 1'b0;
                    ctrl[`SPMS_CTRL_MASTER] <= 1'b0;
                end
            end
            if (wr_in && hit_pre)
                prescale <= wdata_in;
            if (fault) begin
                ctrl[`SPMS_CTRL_POE]    <= 1'b0;
                ctrl[`SPMS_CTRL_MASTER] <= 1'b0;
            end
        end
    end

    // ==================================================
    // Interrupt: done needs source select and enable; fault needs enable only
    assign irq_out = ctrl[`SPMS_CTRL_IRQEN] &&
                     ((done_flag && ctrl[`SPMS_CTRL_IRQSRC]) || master_fault_flag_flag);

    // ==================================================
    // Read port, data one cycle after the strobe
    // Status word: spare bits read as zero
    assign status_word = {done_flag, write_collision_flag_flag, 1'b0, master_fault_flag_flag, 4'h0};

    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            rdata_out <= 8'h00;
        else if (rd_in) begin
            case (addr_in)
                `SPMS_OFF_DATA:     rdata_out <= rx_buf;
                `SPMS_OFF_CTRL:     rdata_out <= ctrl;
                `SPMS_OFF_STATUS:   rdata_out <= status_word;
                `SPMS_OFF_PRESCALE: rdata_out <= prescale;
                default:            rdata_out <= 8'h00;
            endcase
        end else
            rdata_out <= 8'h00;
    end
endmodule // spms_port

// ---- pkg/spms_map.vh ----
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPMS_MAP_VH
`define SPMS_MAP_VH
// ==================================================
// Register offsets
`define SPMS_OFF_DATA      3'h0
`define SPMS_OFF_CTRL      3'h1
`define SPMS_OFF_STATUS    3'h2
`define SPMS_OFF_PRESCALE  3'h3
// ==================================================
// Control register fields
`define SPMS_CTRL_IRQEN    7
`define SPMS_CTRL_POE      6
`define SPMS_CTRL_IRQSRC   5
`define SPMS_CTRL_MASTER   4
`define SPMS_CTRL_CLOCK_POLARITY     3
`define SPMS_CTRL_CLOCK_PHASE     2
`define SPMS_CTRL_RATE_HI  1
`define SPMS_CTRL_RATE_LO  0
// ==================================================
// Status register fields
`define SPMS_STAT_DONE     7
`define SPMS_STAT_WRITE_COLLISION_FLAG     6
`define SPMS_STAT_MASTER_FAULT_FLAG     4
// ==================================================
// Prescaler register fields
`define SPMS_PRE_HALF      7
`define SPMS_PRE_VAL_HI    6
// ==================================================
// Reset values
`define SPMS_RST_CTRL      8'h00
`define SPMS_RST_PRESCALE  8'h00
`define SPMS_RST_BYTE      8'h00
// ==================================================
// Timing
`define SPMS_BITS_PER_BYTE 4'h8
`define SPMS_EDGES_PER_BYTE 5'h10
`endif

// ---- hw/spms_baud_gen.v ----
// Master serial clock rate generator: one-cycle tick per half serial clock period
`timescale 1ns/10ps
module spms_baud_gen #(
    parameter CNT_W = 16
) (
    input  wire       sys_clk_in,
    input  wire       rst_n_in,
    input  wire       run_in,
    input  wire       half_divide_select_in,
    input  wire [6:0] prescale_in,
    input  wire [1:0] rate_select_in,
    output reg        tick_out
);
    // ==================================================
    // Divider: (prescale+1) * 2^(rate+1), halved when selected
    reg  [CNT_W-1:0] count;
    wire [CNT_W-1:0] base_div;
    wire [CNT_W-1:0] full_div;
    wire [CNT_W-1:0] last_val;
    wire [2:0]       shift_amt;

    // Widened so rate three does not wrap to a shift of zero
    assign shift_amt = {1'b0, rate_select_in} + 3'b001;
    assign base_div = {{(CNT_W-7){1'b0}}, prescale_in} + {{(CNT_W-1){1'b0}}, 1'b1};
    assign full_div = base_div << shift_amt;
    assign last_val = half_divide_select_in ? ((full_div >> 1) - {{(CNT_W-1){1'b0}}, 1'b1})
                                            : (full_div - {{(CNT_W-1){1'b0}}, 1'b1});

    always @(posedge sys_clk_in) begin
        if (!rst_n_in || !run_in) begin
            count    <= {CNT_W{1'b0}};
            tick_out <= 1'b0;
        end else if (count >= last_val) begin
            count    <= {CNT_W{1'b0}};
            tick_out <= 1'b1;
        end else begin
            count    <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
        end
    end
endmodule // spms_baud_gen

// ---- hw/spms_shifter.v ----
// Eight-bit shift register with byte load, MSB-first shift and sample hold
`timescale 1ns/10ps
module spms_shifter #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk_in,
    input  wire             rst_n_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] load_data_in,
    input  wire             sample_in,
    input  wire             serial_in,
    input  wire             shift_in,
    output wire             msb_out,
    output wire [WIDTH-1:0] data_out
);
    // ==================================================
    // Sampled bit is held until the shift edge, so capture and launch can be apart
    reg [WIDTH-1:0] shreg;
    reg             held_bit;

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            shreg    <= {WIDTH{1'b0}};
            held_bit <= 1'b0;
        end else begin
            if (sample_in)
                held_bit <= serial_in;
            if (load_in)
                shreg <= load_data_in;
            else if (shift_in)
                shreg <= {shreg[WIDTH-2:0], sample_in ? serial_in : held_bit};
        end
    end

    assign msb_out  = shreg[WIDTH-1];
    assign data_out = sample_in ? {shreg[WIDTH-2:0], serial_in} : {shreg[WIDTH-2:0], held_bit};
endmodule // spms_shifter

// ---- tb/spms_port_props.sv ----
// Concurrent checks on the serial port top-level ports
`timescale 1ns/10ps
module spms_port_props (
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       sck_out,
    input wire logic       sck_oe_out,
    input wire logic       mosi_oe_out,
    input wire logic       miso_oe_out,
    input wire logic       ss_n_in,
    input wire logic       irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ====================
    // Shadow control and serial clock edge count
    logic [7:0] ctrl_sh;
    logic [3:0] tog;
    logic [2:0] cw_d;
    logic       sck_d;
    logic       stat_acc;
    wire        ctrl_wr = wr_in && addr_in == 3'h1;
    always @(posedge sys_clk_in) begin
        sck_d <= sck_out;
        if (!rst_n_in) begin
            ctrl_sh  <= 8'h00;
            tog      <= 4'h0;
            cw_d     <= 3'h0;
            stat_acc <= 1'b0;
        end else begin
            cw_d     <= {cw_d[1:0], ctrl_wr};
            stat_acc <= irq_out && (stat_acc || ((rd_in || wr_in) && addr_in == 3'h2));
            if (ctrl_wr)
                ctrl_sh <= wdata_in;
            // Idle level moves after a control write; not a transfer edge
            if (ctrl_wr || cw_d != 3'h0)
                tog <= 4'h0;
            else if (sck_oe_out && sck_out != sck_d)
                tog <= tog + 4'h1;
        end
    end
    // ====================
    // Properties
    sequence s_data_wr;
        wr_in && addr_in == 3'h0;
    endsequence
    sequence s_done_rd;
        rd_in && addr_in == 3'h2 ##1 rdata_out[7];
    endsequence
    property p_idle_level; ctrl_wr |-> ##3 sck_out == ctrl_sh[3]; endproperty
    property p_done_edges; s_done_rd ##0 sck_oe_out |-> tog == 4'h0; endproperty
    property p_blocked;
        s_data_wr ##0 (sck_oe_out && irq_out && ctrl_sh[5] && !stat_acc) |=> $stable(sck_out) [*8];
    endproperty
    property p_start;
        s_data_wr ##0 (sck_oe_out && !irq_out && ctrl_sh[7] && ctrl_sh[5] && tog == 4'h0)
            |-> ##[1:1000] sck_out != $past(sck_out);
    endproperty
    property p_irq; irq_out |-> ctrl_sh[7]; endproperty
    property p_sck_oe; sck_oe_out |-> ctrl_sh[4] && ctrl_sh[6]; endproperty
    property p_fault; sck_oe_out && !ss_n_in |-> ##[1:6] !sck_oe_out && !mosi_oe_out; endproperty
    property p_mosi_oe; sck_oe_out |-> mosi_oe_out && !miso_oe_out; endproperty
    property p_miso_oe; miso_oe_out |-> !sck_oe_out && !mosi_oe_out && !ctrl_sh[4]; endproperty
    a_idle_level: assert property (p_idle_level) else $error("serial clock idle level wrong");
    a_done_edges: assert property (p_done_edges) else $error("done without sixteen edges");
    a_blocked: assert property (p_blocked) else $error("data write accepted while done");
    a_start: assert property (p_start) else $error("data write did not start transfer");
    a_irq: assert property (p_irq) else $error("interrupt without enable");
    a_sck_oe: assert property (p_sck_oe) else $error("clock driven outside master mode");
    a_fault: assert property (p_fault) else $error("master fault did not release pins");
    a_mosi_oe: assert property (p_mosi_oe) else $error("master pin directions wrong");
    a_miso_oe: assert property (p_miso_oe) else $error("slave pin directions wrong");
endmodule // spms_port_props

bind spms_port spms_port_props u_props (
    .sys_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sck_out, .sck_oe_out, .mosi_oe_out, .miso_oe_out, .ss_n_in, .irq_out
);

// ---- tb/spms_far_model.sv ----
// Behavioural far-side device: slave to the port as master, master to the port as slave
`timescale 1ns/10ps
module spms_far_model (
    input  wire logic sys_clk_in,
    input  wire logic sck_in,
    input  wire logic mosi_in,
    input  wire logic miso_in,
    output logic      sck_out,
    output logic      mosi_out,
    output logic      miso_out,
    output logic      ss_n_out
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    logic       ph = 1'b0;
    logic       armed = 1'b0;
    int         cnt = 0;
    initial begin
        sck_out  = 1'b0;
        mosi_out = 1'b0;
        miso_out = 1'b1;
        ss_n_out = 1'b1;
    end
    // ====================
    // Slave role
    task automatic arm(input logic [7:0] d, input logic clock_phase);
        sh = d;
        rx = 8'h00;
        ph = clock_phase;
        cnt = 0;
        armed = 1'b1;
        if (!clock_phase)
            miso_out = d[7];
    endtask
    always @(sck_in) if (armed) begin
        if (cnt < 16) begin
            if (cnt[0] == ph)
                rx = {rx[6:0], mosi_in};
            else if (!ph) begin
                sh = sh << 1;
                miso_out = sh[7];
            end else begin
                miso_out = sh[7];
                sh = sh << 1;
            end
        end
        cnt++;
        // Released line must not keep its last bit
        if (cnt == 16)
            miso_out = ~miso_out;
    end
    // ====================
    // Master role
    task automatic sel(input logic v);
        @(posedge sys_clk_in);
        ss_n_out <= v;
    endtask
    task automatic xfer(input logic [7:0] d, input logic pol, input logic clock_phase, output logic [7:0] got);
        logic [7:0] s;
        s = d;
        got = 8'h00;
        armed = 1'b0;
        @(posedge sys_clk_in);
        sck_out <= pol;
        @(posedge sys_clk_in);
        mosi_out <= d[7];
        ss_n_out <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        for (int i = 0; i < 16; i++) begin
            sck_out <= ~sck_out;
            if (i % 2 == clock_phase)
                got = {got[6:0], miso_in};
            else if (!clock_phase) begin
                s = s << 1;
                mosi_out <= s[7];
            end else begin
                mosi_out <= s[7];
                s = s << 1;
            end
            // Half period of four cycles stays below half the internal rate
            repeat (4) @(posedge sys_clk_in);
        end
        ss_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
    endtask
endmodule // spms_far_model

// ---- tb/spms_port_tb_top.sv ----
// Self-checking testbench of the serial port
`timescale 1ns/10ps
module spms_port_tb_top;
    logic       sys_clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    wire  [7:0] rdata_out;
    wire        sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, irq_out;
    wire        m_sck, m_mosi, m_miso, ss_n;
    wire        sck_w = sck_oe_out ? sck_out : m_sck;
    wire        mosi_w = mosi_oe_out ? mosi_out : m_mosi;
    wire        miso_w = miso_oe_out ? miso_out : m_miso;
    int         n_fail = 0;
    int         tests_run = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    spms_port i_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe_out(sck_oe_out), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .ss_n_in(ss_n),
        .irq_out(irq_out)
    );
    spms_far_model i_far (
        .sys_clk_in(sys_clk_in), .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .sck_out(m_sck), .mosi_out(m_mosi), .miso_out(m_miso), .ss_n_out(ss_n)
    );
    // ====================
    // Bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    task automatic wait_irq;
        int k;
        for (k = 0; k < 4000 && irq_out !== 1'b1; k++)
            @(posedge sys_clk_in);
        chk({7'h00, irq_out}, 8'h01);
    endtask
    // ====================
    // Scenarios
    task automatic t_master(input logic [3:0] lo, input logic [7:0] pre, input logic [7:0] tx,
                            input logic [7:0] rx, input int half);
        int k;
        int c;
        int t1;
        logic p;
        wr(3'h3, pre);
        wr(3'h1, {4'hf, lo});
        rd_chk(3'h1, {4'hf, lo});
        i_far.arm(rx, lo[2]);
        wr(3'h0, tx);
        wr(3'h0, 8'hff);
        p = sck_out;
        c = 0;
        t1 = 0;
        for (k = 0; k < 3000 && c < 3; k++) begin
            @(posedge sys_clk_in);
            #1;
            if (sck_out !== p) begin
                c++;
                if (c == 2)
                    t1 = k;
                if (c == 3)
                    chk(8'(k - t1), 8'(half));
            end
            p = sck_out;
        end
        wait_irq;
        wr(3'h0, 8'h11);
        repeat (40) @(posedge sys_clk_in);
        chk(8'(i_far.cnt), 8'h10);
        rd_chk(3'h2, 8'hc0);
        rd_chk(3'h0, rx);
        rd_chk(3'h2, 8'h00);
        chk(i_far.rx, tx);
        chk({7'h00, irq_out}, 8'h00);
        $display("master test done, ctrl %h", {4'hf, lo});
    endtask
    task automatic t_fault;
        wr(3'h1, 8'hf0);
        i_far.sel(1'b0);
        repeat (8) @(posedge sys_clk_in);
        chk({7'h00, irq_out}, 8'h01);
        rd_chk(3'h1, 8'ha0);
        rd_chk(3'h2, 8'h10);
        i_far.sel(1'b1);
        wr(3'h1, 8'h00);
        rd_chk(3'h2, 8'h00);
        $display("fault test done");
    endtask
    task automatic t_slave(input logic [1:0] m, input logic [7:0] tx, input logic [7:0] rx);
        logic [7:0] got;
        wr(3'h1, {4'he, m, 2'h3});
        wr(3'h0, tx);
        i_far.xfer(rx, m[1], m[0], got);
        chk(got, tx);
        wait_irq;
        rd_chk(3'h2, 8'h80);
        rd_chk(3'h0, rx);
        rd_chk(3'h2, 8'h00);
        $display("slave test done, mode %h", m);
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ====================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h3, 8'h00);
        rd_chk(3'h5, 8'h00);
        for (int i = 0; i < 4; i++)
            t_master({i[1:0], 2'h0}, 8'h00, 8'ha5 ^ 8'(i), 8'h3c + 8'(i), 2);
        t_master(4'h1, 8'h01, 8'h81, 8'h7e, 8);
        t_master(4'h1, 8'h81, 8'h18, 8'he7, 4);
        t_master(4'h3, 8'h00, 8'hc3, 8'h3a, 16);
        t_fault;
        for (int i = 0; i < 4; i++)
            t_slave(i[1:0], 8'h96 ^ 8'(i), 8'h5a + 8'(i));
        summarize;
    end
    initial begin
        #200_000;
        n_fail++;
        summarize;
    end
endmodule // spms_port_tb_top
